// >>> logic/rbg_pkg.sv
// Purpose: Shared constants for the receive buffer guard and delimiter block
// Assumes: Register port gives 6-bit addresses and 8-bit data
// Notes: Offsets are the printed register addresses
package rbg_pkg;
   localparam logic [5:0] RBG_OFS_MISC = 6'h04;
   localparam logic [5:0] RBG_OFS_DELIM = 6'h0B;
   localparam logic [5:0] RBG_OFS_GUARD = 6'h0C;
   localparam logic [7:0] RBG_RST_MISC = 8'h20;
   localparam logic [7:0] RBG_RST_DELIM = 8'hA7;
   localparam logic [7:0] RBG_RST_GUARD = 8'h00;
   localparam logic [7:0] RBG_GUARD_WMASK = 8'h83;
   localparam int RBG_BIT_IND_EN = 4;
   localparam int RBG_BIT_GUARD_EN = 7;
   localparam int RBG_IND_LAT_NS = 750;
   localparam int RBG_CLK_NS = 8;
   localparam int RBG_IND_LAT_CYC = (RBG_IND_LAT_NS + RBG_CLK_NS - 1) / RBG_CLK_NS;
   localparam logic [2:0] RBG_LAST_BIT = 3'h7;
   localparam logic [2:0] RBG_TX_BITS_LEFT = 3'h7;
   typedef enum logic [1:0] {RBG_HUNT, RBG_HDR, RBG_BODY} rbg_rx_st_t;
endpackage : rbg_pkg

// >>> logic/rbg_sync.sv
// Purpose: Three-stage synchroniser for a pin level
// Assumes: Input is asynchronous to clk
// Notes: Output follows only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module rbg_sync (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic din,
   output logic dout
);
   logic s1;
   logic s2;
   logic s3;
   logic next_dout;

   always_comb
   begin
      next_dout = dout;
      if (s2 == s3)
      begin
         next_dout = s3;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         dout <= 1'b1;
      end
      else
      begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         dout <= next_dout;
      end
   end
endmodule : rbg_sync
`default_nettype wire

// >>> logic/rbg_top.sv
// Purpose: Receive buffer guard, buffer-empty indicator and frame delimiter
// Assumes: SPI decoder, interrupt logic and FCS checker sit outside on clk
// Notes: Chip select is the only pin input and is synchronised here
// Functional notes
// R1: With indicator enabled, after buffer read command, irq shows data missing.
// R2: While indicator mode is active, irq carries no interrupt events.
// R3: Indicator enable bit: 0 disables (default), 1 enables.
// R4: Keep receiving frames while in either receive state.
// R5: Unprotected buffer is overwritten by the next received frame.
// R6: Protection blocks new radio frames until buffer read ends at select high.
// R7: Basic mode protects a frame only when its check sequence is valid.
// R8: Extended mode protects a frame when its frame-end event fires.
// R9: Protection active only with enable bit 7 set and in a receive state.
// R10: Protection blocks radio writes only; host writes still reach the buffer.
// R11: Release on select rise ending buffer read, or on leaving receive states.
// R12: Protection ignores the receiver detection threshold setting.
// R13: Delimiter octet aligns bytes and is never stored.
// R14: No synchronisation when the received octet differs from the delimiter.
// R15: Software should avoid delimiters with low four bits all zero.
// R16: Transmit delimiter LSB first right after the last preamble bit.
// R17: Delimiter register resets to the standard value.
// R18: Delimiter register accepts any 8-bit value.
// R19: Frame-start event only on delimiter match followed by valid header.
// R20: Guard register bits 6..2 read zero, read-only; bits 1..0 read-write.
// R21: Indicator shows a valid level no earlier than the fixed latency.
// R22: Indicator low when next byte readable, high when not ready.
// R23: Receive error during buffer read locks the indicator at empty.
// R24: Select high ends indicator mode; pending interrupts show at once.
// R25: Reset clears any held protection.
`timescale 1ns/1ps
`default_nettype none
module rbg_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic spi_sel_n,
   input wire logic fb_read_cmd,
   input wire logic host_rd_strobe,
   input wire logic host_wr,
   input wire logic [6:0] host_waddr,
   input wire logic [7:0] host_wdata,
   input wire logic rx_on_state,
   input wire logic rx_auto_ack_state,
   input wire logic ext_mode,
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_fcs_ok,
   input wire logic rx_error,
   input wire logic irq_pending,
   input wire logic frame_start_en,
   input wire logic tx_sfd_start,
   input wire logic tx_bit_tick,
   output logic irq_out,
   output logic fb_we,
   output logic [6:0] fb_waddr,
   output logic [7:0] fb_wdata,
   output logic frame_start_event,
   output logic frame_end_event,
   output logic tx_bit,
   output logic tx_bit_valid,
   output logic guard_active,
   output logic [7:0] radio_misc_ctrl,
   output logic [1:0] phy_rate_select
);
   function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] ofs);
      reg_hit = (addr == ofs);
   endfunction : reg_hit

   logic sel_n_s;
   logic sel_n_d;
   logic sel_rise;
   logic rx_active;
   logic guard_on;

   rbg_sync u_sel (
      .clk(clk),
      .sys_rst(sys_rst),
      .din(spi_sel_n),
      .dout(sel_n_s)
   );

   assign sel_rise = sel_n_s & ~sel_n_d;
   assign rx_active = rx_on_state | rx_auto_ack_state;

   // Registers
   logic [7:0] delimiter_octet;
   logic [7:0] rx_guard_rate_ctrl;
   logic [7:0] next_delim;
   logic [7:0] next_guard;
   logic [7:0] next_misc;
   logic [7:0] next_rdata;

   always_comb
   begin
      next_delim = delimiter_octet;
      next_guard = rx_guard_rate_ctrl;
      next_misc = radio_misc_ctrl;
      next_rdata = 8'h00;
      if (reg_wr)
      begin
         if (reg_hit(reg_addr, rbg_pkg::RBG_OFS_DELIM))
         begin
            next_delim = reg_wdata; // R18
         end
         if (reg_hit(reg_addr, rbg_pkg::RBG_OFS_GUARD))
         begin
            next_guard = reg_wdata & rbg_pkg::RBG_GUARD_WMASK; // R20
         end
         if (reg_hit(reg_addr, rbg_pkg::RBG_OFS_MISC))
         begin
            next_misc = reg_wdata; // R3
         end
      end
      if (reg_rd)
      begin
         if (reg_hit(reg_addr, rbg_pkg::RBG_OFS_DELIM))
         begin
            next_rdata = delimiter_octet;
         end
         else if (reg_hit(reg_addr, rbg_pkg::RBG_OFS_GUARD))
         begin
            next_rdata = rx_guard_rate_ctrl; // R20
         end
         else if (reg_hit(reg_addr, rbg_pkg::RBG_OFS_MISC))
         begin
            next_rdata = radio_misc_ctrl;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         delimiter_octet <= rbg_pkg::RBG_RST_DELIM; // R17
         rx_guard_rate_ctrl <= rbg_pkg::RBG_RST_GUARD;
         radio_misc_ctrl <= rbg_pkg::RBG_RST_MISC; // R3
         reg_rdata <= 8'h00;
         phy_rate_select <= 2'h0;
         sel_n_d <= 1'b1;
      end
      else
      begin
         delimiter_octet <= next_delim;
         rx_guard_rate_ctrl <= next_guard;
         radio_misc_ctrl <= next_misc;
         reg_rdata <= next_rdata;
         phy_rate_select <= next_guard[1:0];
         sel_n_d <= sel_n_s;
      end
   end

   // Threshold setting has no input here on purpose
   assign guard_on = rx_guard_rate_ctrl[rbg_pkg::RBG_BIT_GUARD_EN] & rx_active; // R9 R12

   // Receive path
   rbg_pkg::rbg_rx_st_t rx_st;
   rbg_pkg::rbg_rx_st_t next_rx_st;
   logic [7:0] rx_sh;
   logic [7:0] next_rx_sh;
   logic [7:0] shifted;
   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   logic [6:0] frame_len;
   logic [6:0] next_frame_len;
   logic [6:0] pos;
   logic [6:0] next_pos;
   logic [7:0] fill;
   logic [7:0] next_fill;
   logic buf_full;
   logic next_buf_full;
   logic blocked;
   logic next_blocked;
   logic protect;
   logic next_protect;
   logic fb_rd_open;
   logic rx_we;
   logic [6:0] rx_waddr;
   logic next_fb_we;
   logic [6:0] next_fb_waddr;
   logic [7:0] next_fb_wdata;
   logic next_start_ev;
   logic next_end_ev;

   always_comb
   begin
      next_rx_st = rx_st;
      next_rx_sh = rx_sh;
      next_bit_cnt = bit_cnt;
      next_frame_len = frame_len;
      next_pos = pos;
      next_fill = fill;
      next_buf_full = buf_full;
      next_blocked = blocked;
      next_protect = protect;
      next_start_ev = 1'b0;
      next_end_ev = 1'b0;
      rx_we = 1'b0;
      rx_waddr = 7'h00;
      shifted = {rx_bit, rx_sh[7:1]};
      // Release first so a same-cycle set below wins
      if ((sel_rise & fb_rd_open) | ~guard_on)
      begin
         next_protect = 1'b0; // R11
      end
      case (rx_st)
         rbg_pkg::RBG_HUNT:
         begin
            if (rx_bit_valid)
            begin
               next_rx_sh = shifted;
               if (shifted == delimiter_octet) // R14
               begin
                  next_rx_st = rbg_pkg::RBG_HDR; // R13
                  next_bit_cnt = 3'h0;
                  next_blocked = protect; // R6
               end
            end
         end
         rbg_pkg::RBG_HDR:
         begin
            if (rx_bit_valid)
            begin
               next_rx_sh = shifted;
               next_bit_cnt = bit_cnt + 3'h1;
               if (bit_cnt == rbg_pkg::RBG_LAST_BIT)
               begin
                  if (shifted[6:0] != 7'h00)
                  begin
                     next_rx_st = rbg_pkg::RBG_BODY;
                     next_frame_len = shifted[6:0];
                     next_pos = 7'h00;
                     next_start_ev = frame_start_en; // R19
                     if (!blocked)
                     begin
                        rx_we = 1'b1; // R5
                        next_fill = 8'h01;
                        next_buf_full = 1'b0;
                     end
                  end
                  else
                  begin
                     next_rx_st = rbg_pkg::RBG_HUNT;
                  end
               end
            end
         end
         rbg_pkg::RBG_BODY:
         begin
            if (rx_bit_valid)
            begin
               next_rx_sh = shifted;
               next_bit_cnt = bit_cnt + 3'h1;
               if (bit_cnt == rbg_pkg::RBG_LAST_BIT)
               begin
                  rx_waddr = pos + 7'h01;
                  next_pos = pos + 7'h01;
                  if (!blocked)
                  begin
                     rx_we = 1'b1; // R6
                     next_fill = fill + 8'h01;
                  end
                  if (next_pos == frame_len)
                  begin
                     next_rx_st = rbg_pkg::RBG_HUNT;
                     next_end_ev = 1'b1;
                     if (!blocked)
                     begin
                        next_buf_full = 1'b1;
                        if (guard_on & (ext_mode | rx_fcs_ok)) // R7 R8
                        begin
                           next_protect = 1'b1;
                        end
                     end
                  end
               end
            end
         end
         default:
         begin
            next_rx_st = rbg_pkg::RBG_HUNT;
         end
      endcase
      if (rx_error)
      begin
         next_rx_st = rbg_pkg::RBG_HUNT;
      end
      if (!rx_active)
      begin
         next_rx_st = rbg_pkg::RBG_HUNT; // R4
      end
      // Host write takes the port; a colliding radio byte is dropped
      next_fb_we = host_wr | rx_we; // R10
      next_fb_waddr = host_wr ? host_waddr : rx_waddr;
      next_fb_wdata = host_wr ? host_wdata : shifted;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rx_st <= rbg_pkg::RBG_HUNT;
         rx_sh <= 8'h00;
         bit_cnt <= 3'h0;
         frame_len <= 7'h00;
         pos <= 7'h00;
         fill <= 8'h00;
         buf_full <= 1'b0;
         blocked <= 1'b0;
         protect <= 1'b0; // R25
         guard_active <= 1'b0;
         fb_we <= 1'b0;
         fb_waddr <= 7'h00;
         fb_wdata <= 8'h00;
         frame_start_event <= 1'b0;
         frame_end_event <= 1'b0;
      end
      else
      begin
         rx_st <= next_rx_st;
         rx_sh <= next_rx_sh;
         bit_cnt <= next_bit_cnt;
         frame_len <= next_frame_len;
         pos <= next_pos;
         fill <= next_fill;
         buf_full <= next_buf_full;
         blocked <= next_blocked;
         protect <= next_protect;
         guard_active <= next_protect;
         fb_we <= next_fb_we;
         fb_waddr <= next_fb_waddr;
         fb_wdata <= next_fb_wdata;
         frame_start_event <= next_start_ev;
         frame_end_event <= next_end_ev;
      end
   end

   // Buffer-empty indicator on the interrupt pin
   logic ind_mode;
   logic next_ind_mode;
   logic next_rd_open;
   logic [7:0] rd_cnt;
   logic [7:0] next_rd_cnt;
   logic [6:0] lat_cnt;
   logic [6:0] next_lat_cnt;
   logic err_lock;
   logic next_err_lock;
   logic empty;
   logic next_irq;

   always_comb
   begin
      next_ind_mode = ind_mode;
      next_rd_open = fb_rd_open;
      next_rd_cnt = rd_cnt;
      next_lat_cnt = lat_cnt;
      next_err_lock = err_lock;
      if (fb_read_cmd)
      begin
         next_rd_open = 1'b1;
         next_rd_cnt = 8'h00;
         next_lat_cnt = 7'(rbg_pkg::RBG_IND_LAT_CYC); // R21
         next_err_lock = 1'b0;
         next_ind_mode = radio_misc_ctrl[rbg_pkg::RBG_BIT_IND_EN]; // R1 R3
      end
      else
      begin
         if (lat_cnt != 7'h00)
         begin
            next_lat_cnt = lat_cnt - 7'h01;
         end
         if (host_rd_strobe)
         begin
            next_rd_cnt = rd_cnt + 8'h01;
         end
      end
      // Lock beats the clear of a new command
      if (rx_error & next_ind_mode)
      begin
         next_err_lock = 1'b1; // R23
      end
      if (sel_rise)
      begin
         next_ind_mode = 1'b0; // R24
         next_rd_open = 1'b0;
      end
      // Latency window reads as not ready so no early allowed level escapes
      empty = err_lock | (lat_cnt != 7'h00) | (~buf_full & (fill <= rd_cnt)); // R22
      // Command edge itself reads not ready; counters are still stale
      next_irq = next_ind_mode ? (fb_read_cmd | empty) : irq_pending; // R2 R21
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ind_mode <= 1'b0;
         fb_rd_open <= 1'b0;
         rd_cnt <= 8'h00;
         lat_cnt <= 7'h00;
         err_lock <= 1'b0;
         irq_out <= 1'b0;
      end
      else
      begin
         ind_mode <= next_ind_mode;
         fb_rd_open <= next_rd_open;
         rd_cnt <= next_rd_cnt;
         lat_cnt <= next_lat_cnt;
         err_lock <= next_err_lock;
         irq_out <= next_irq;
      end
   end

   // Delimiter transmitter
   logic [7:0] tx_sh;
   logic [7:0] next_tx_sh;
   logic [2:0] tx_left;
   logic [2:0] next_tx_left;
   logic next_tx_bit;
   logic next_tx_valid;

   always_comb
   begin
      next_tx_sh = tx_sh;
      next_tx_left = tx_left;
      next_tx_bit = tx_bit;
      next_tx_valid = tx_bit_valid;
      if (tx_sfd_start)
      begin
         next_tx_sh = delimiter_octet;
         next_tx_bit = delimiter_octet[0]; // R16
         next_tx_left = rbg_pkg::RBG_TX_BITS_LEFT;
         next_tx_valid = 1'b1;
      end
      else if (tx_bit_tick & tx_bit_valid)
      begin
         if (tx_left == 3'h0)
         begin
            next_tx_valid = 1'b0;
            next_tx_bit = 1'b0;
         end
         else
         begin
            next_tx_bit = tx_sh[1]; // R16
            next_tx_sh = {1'b0, tx_sh[7:1]};
            next_tx_left = tx_left - 3'h1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         tx_sh <= 8'h00;
         tx_left <= 3'h0;
         tx_bit <= 1'b0;
         tx_bit_valid <= 1'b0;
      end
      else
      begin
         tx_sh <= next_tx_sh;
         tx_left <= next_tx_left;
         tx_bit <= next_tx_bit;
         tx_bit_valid <= next_tx_valid;
      end
   end
endmodule : rbg_top
`default_nettype wire

// >>> dv/rbg_top_sva.sv
// Purpose: Port-level checks for the receive buffer guard block
// Assumes: Single clk domain, sys_rst synchronous active high
// Notes: Shadows the guard enable bit because it has no port of its own
`timescale 1ns/1ps
`default_nettype none
module rbg_top_sva (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic fb_read_cmd,
   input wire logic [7:0] radio_misc_ctrl,
   input wire logic irq_out,
   input wire logic irq_pending,
   input wire logic frame_start_event,
   input wire logic frame_start_en,
   input wire logic guard_active,
   input wire logic fb_we,
   input wire logic [6:0] fb_waddr,
   input wire logic frame_end_event,
   input wire logic rx_on_state,
   input wire logic rx_auto_ack_state,
   input wire logic ext_mode,
   input wire logic rx_fcs_ok
);
   logic guard_sh;
   logic [6:0] lat_cnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Counter stands in for a 94-cycle repetition the tools cannot unroll
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         guard_sh <= 1'b0;
         lat_cnt <= 7'h00;
      end
      else
      begin
         if (reg_wr && reg_addr == rbg_pkg::RBG_OFS_GUARD)
            guard_sh <= reg_wdata[rbg_pkg::RBG_BIT_GUARD_EN];
         if (fb_read_cmd && radio_misc_ctrl[rbg_pkg::RBG_BIT_IND_EN])
            lat_cnt <= 7'(rbg_pkg::RBG_IND_LAT_CYC);
         else if (lat_cnt != 7'h00)
            lat_cnt <= lat_cnt - 7'h01;
      end
   end
   sequence s_protect_cause;
      frame_end_event && guard_sh && $past(rx_on_state || rx_auto_ack_state)
         && $past(ext_mode || rx_fcs_ok);
   endsequence
   sequence s_rx_gone;
      (!(rx_on_state || rx_auto_ack_state)) [*3];
   endsequence
   a_rd_unmapped_zero: assert property (reg_rd && reg_addr != rbg_pkg::RBG_OFS_MISC
      && reg_addr != rbg_pkg::RBG_OFS_DELIM && reg_addr != rbg_pkg::RBG_OFS_GUARD
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_guard_rsvd_zero: assert property (reg_rd && reg_addr == rbg_pkg::RBG_OFS_GUARD
      |=> reg_rdata[6:2] == 5'h00) else $error("reserved guard bits not zero");
   a_ind_latency_high: assert property (lat_cnt != 7'h00 |-> irq_out)
      else $error("indicator low inside latency");
   a_irq_follows_pend: assert property (!radio_misc_ctrl[rbg_pkg::RBG_BIT_IND_EN]
      && !$past(radio_misc_ctrl[rbg_pkg::RBG_BIT_IND_EN]) && !$past(sys_rst)
      |-> irq_out == $past(irq_pending)) else $error("irq not following pending");
   a_start_needs_en: assert property (frame_start_event |-> $past(frame_start_en))
      else $error("frame start while disabled");
   a_hdr_at_zero: assert property (frame_start_event && !guard_active
      |-> fb_we && fb_waddr == 7'h00) else $error("header not stored at zero");
   a_guard_sets: assert property (s_protect_cause |=> guard_active)
      else $error("protection not set");
   a_guard_rx_off: assert property (s_rx_gone |-> !guard_active)
      else $error("protection held outside receive");
   a_reset_clears: assert property ($fell(sys_rst) |-> !guard_active && !fb_we)
      else $error("protection left after reset");
endmodule : rbg_top_sva
bind rbg_top rbg_top_sva u_sva (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .fb_read_cmd(fb_read_cmd), .radio_misc_ctrl(radio_misc_ctrl), .irq_out(irq_out),
   .irq_pending(irq_pending), .frame_start_event(frame_start_event),
   .frame_start_en(frame_start_en), .guard_active(guard_active), .fb_we(fb_we),
   .fb_waddr(fb_waddr), .frame_end_event(frame_end_event), .rx_on_state(rx_on_state),
   .rx_auto_ack_state(rx_auto_ack_state), .ext_mode(ext_mode), .rx_fcs_ok(rx_fcs_ok));
`default_nettype wire

// >>> dv/rbg_host_model.sv
// Purpose: Host side of a frame buffer read over the select pin
// Assumes: Drives on falling clk edges like the bench
// Notes: Byte transfer itself is reduced to one strobe
`timescale 1ns/1ps
`default_nettype none
module rbg_host_model (
   input wire logic clk,
   input wire logic irq_out,
   output logic spi_sel_n,
   output logic fb_read_cmd,
   output logic host_rd_strobe
);
   int stall_cyc;
   initial
   begin
      spi_sel_n = 1'b1;
      fb_read_cmd = 1'b0;
      host_rd_strobe = 1'b0;
      stall_cyc = 0;
   end
   task automatic fb_read(input int nbytes);
      int w;
      @(negedge clk) spi_sel_n = 1'b0;
      @(negedge clk) fb_read_cmd = 1'b1;
      @(negedge clk) fb_read_cmd = 1'b0;
      stall_cyc = 0;
      for (int i = 0; i < nbytes; i++)
      begin
         w = 0;
         // Bounded wait so a stuck indicator cannot hang the host
         while (irq_out !== 1'b0 && w < 300)
         begin
            @(negedge clk);
            w++;
         end
         stall_cyc += w;
         @(negedge clk) host_rd_strobe = 1'b1;
         @(negedge clk) host_rd_strobe = 1'b0;
      end
      @(negedge clk) spi_sel_n = 1'b1;
   endtask : fb_read
endmodule : rbg_host_model
`default_nettype wire

// >>> dv/rx_buffer_guard_and_sfd_tb_top.sv
// Purpose: Self-checking bench for the receive buffer guard block
// Assumes: Expected buffer writes and reads queued by the drivers
// Notes: Delimiter keeps bits 7 and 0 set so zero fill never fakes a match
`timescale 1ns/1ps
`default_nettype none
module rx_buffer_guard_and_sfd_tb_top;
   logic clk, sys_rst, reg_wr, reg_rd, host_wr, rx_on_state, rx_auto_ack_state, ext_mode;
   logic rx_bit_valid, rx_bit, rx_fcs_ok, rx_error, irq_pending, frame_start_en;
   logic tx_sfd_start, tx_bit_tick, spi_sel_n, fb_read_cmd, host_rd_strobe, irq_out, fb_we;
   logic frame_start_event, frame_end_event, tx_bit, tx_bit_valid, guard_active, rd_d;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, host_wdata, fb_wdata, radio_misc_ctrl, d;
   logic [6:0] host_waddr, fb_waddr;
   logic [1:0] phy_rate_select;
   logic [15:0] wq[$];
   logic [7:0] rq[$];
   int fails, cmp_count, cyc;
   rbg_top dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .spi_sel_n(spi_sel_n), .fb_read_cmd(fb_read_cmd), .host_rd_strobe(host_rd_strobe),
      .host_wr(host_wr), .host_waddr(host_waddr), .host_wdata(host_wdata),
      .rx_on_state(rx_on_state), .rx_auto_ack_state(rx_auto_ack_state), .ext_mode(ext_mode),
      .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_fcs_ok(rx_fcs_ok),
      .rx_error(rx_error), .irq_pending(irq_pending), .frame_start_en(frame_start_en),
      .tx_sfd_start(tx_sfd_start), .tx_bit_tick(tx_bit_tick), .irq_out(irq_out),
      .fb_we(fb_we), .fb_waddr(fb_waddr), .fb_wdata(fb_wdata),
      .frame_start_event(frame_start_event), .frame_end_event(frame_end_event),
      .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .guard_active(guard_active),
      .radio_misc_ctrl(radio_misc_ctrl), .phy_rate_select(phy_rate_select));
   rbg_host_model host (.clk(clk), .irq_out(irq_out), .spi_sel_n(spi_sel_n),
      .fb_read_cmd(fb_read_cmd), .host_rd_strobe(host_rd_strobe));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic report_and_stop;
      if (fails == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   always @(posedge clk)
   begin
      rd_d <= reg_rd;
      cyc <= cyc + 1;
      if (rd_d === 1'b1)
         chk("reg_rdata", {8'h00, rq.pop_front()}, {8'h00, reg_rdata});
      if (fb_we === 1'b1)
         chk("fb_write", wq.size() ? wq.pop_front() : 16'hFFFF, {1'b0, fb_waddr, fb_wdata});
      if (cyc == 20000)
      begin
         fails++;
         report_and_stop();
      end
   end
   task automatic reg_write(input logic [5:0] a, input logic [7:0] v);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [5:0] a, input logic [7:0] e);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      rq.push_back(e);
      @(negedge clk);
      reg_rd = 1'b0;
   endtask : reg_read
   task automatic send_octet(input logic [7:0] b);
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk);
         rx_bit_valid = 1'b1;
         rx_bit = b[i];
      end
   endtask : send_octet
   task automatic send_frame(input logic [7:0] dl, input int len, input bit store);
      logic [7:0] b;
      send_octet(8'h00);
      send_octet(dl);
      send_octet(8'(len));
      if (store)
         wq.push_back({1'b0, 7'h00, 8'(len)});
      for (int i = 1; i <= len; i++)
      begin
         b = 8'($urandom);
         if (store)
            wq.push_back({1'b0, 7'(i), b});
         send_octet(b);
      end
      @(negedge clk);
      rx_bit_valid = 1'b0;
      repeat (4) @(negedge clk);
   endtask : send_frame
   initial
   begin
      {reg_wr, reg_rd, host_wr, rx_on_state, rx_auto_ack_state, ext_mode} = 6'h00;
      {rx_bit_valid, rx_bit, rx_fcs_ok, rx_error, irq_pending, tx_sfd_start} = 6'h00;
      {tx_bit_tick, fails, cmp_count, cyc} = '0;
      frame_start_en = 1'b1;
      reg_addr = 6'h00;
      {reg_wdata, host_wdata, host_waddr} = '0;
      sys_rst = 1'b1;
      void'($urandom(32'h9220));
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      reg_read(6'h04, 8'h20);
      reg_read(6'h0B, 8'hA7);
      reg_read(6'h0C, 8'h00);
      reg_read(6'h3F, 8'h00);
      reg_write(6'h0C, 8'hFF);
      reg_read(6'h0C, 8'h83);
      chk("phy_rate_select", 16'h0003, {14'h0000, phy_rate_select});
      // Low nibble kept nonzero as software is told to
      d = 8'($urandom) | 8'h81;
      reg_write(6'h0B, d);
      reg_read(6'h0B, d);
      reg_write(6'h0C, 8'h03);
      rx_on_state = 1'b1;
      send_frame(d, 2, 1'b1);
      frame_start_en = 1'b0;
      send_frame(d, 3, 1'b1);
      frame_start_en = 1'b1;
      send_octet(8'h00);
      send_octet(d ^ 8'h10);
      send_frame(8'h00, 0, 1'b0);
      reg_write(6'h0C, 8'h80);
      send_frame(d, 2, 1'b1);
      chk("guard_bad_fcs", 16'h0000, {15'h0000, guard_active});
      rx_fcs_ok = 1'b1;
      send_frame(d, 1, 1'b1);
      chk("guard_good_fcs", 16'h0001, {15'h0000, guard_active});
      send_frame(d, 2, 1'b0);
      @(negedge clk);
      host_wr = 1'b1;
      host_waddr = 7'h05;
      host_wdata = 8'($urandom);
      wq.push_back({1'b0, 7'h05, host_wdata});
      @(negedge clk);
      host_wr = 1'b0;
      reg_write(6'h04, 8'h30);
      irq_pending = 1'b1;
      host.fb_read(2);
      chk("ind_stall", 16'h0001, {15'h0000, host.stall_cyc >= 90 && host.stall_cyc < 150});
      repeat (8) @(negedge clk);
      chk("guard_release", 16'h0000, {15'h0000, guard_active});
      chk("irq_after_sel", 16'h0001, {15'h0000, irq_out});
      fork
         host.fb_read(1);
         begin
            repeat (20) @(negedge clk);
            rx_error = 1'b1;
            @(negedge clk);
            rx_error = 1'b0;
         end
      join
      chk("ind_err_lock", 16'h012C, 16'(host.stall_cyc));
      {ext_mode, rx_fcs_ok, rx_on_state, rx_auto_ack_state} = 4'h9;
      send_frame(d, 2, 1'b1);
      chk("guard_ext", 16'h0001, {15'h0000, guard_active});
      rx_auto_ack_state = 1'b0;
      repeat (6) @(negedge clk);
      chk("guard_rx_off", 16'h0000, {15'h0000, guard_active});
      @(negedge clk) tx_sfd_start = 1'b1;
      @(negedge clk) tx_sfd_start = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         chk("tx_bit", {14'h0000, 1'b1, d[i]}, {14'h0000, tx_bit_valid, tx_bit});
         @(negedge clk) tx_bit_tick = 1'b1;
         @(negedge clk) tx_bit_tick = 1'b0;
      end
      chk("tx_done", 16'h0000, {15'h0000, tx_bit_valid});
      repeat (10) @(negedge clk);
      chk("queues", 16'h0000, 16'(wq.size() + rq.size()));
      report_and_stop();
   end
endmodule : rx_buffer_guard_and_sfd_tb_top
`default_nettype wire
